//--- common/eac_pkg.sv
// Purpose: Constants for the byte-wide data EEPROM access control block
// Assumes: 20 MHz core clock, 1 MHz write timing oscillator derived by a divider
// Notes: Function list of the block follows
// Function
// (RULE1) Control bits 7..4 always read zero
// (RULE2) Ready irq enable gated by global enable
// (RULE3) Ready irq held while write strobe zero
// (RULE4) Master enable self-clears four cycles later
// (RULE5) Strobe inside window starts byte write
// (RULE6) Strobe without master enable does nothing
// (RULE7) Software waits, loads, arms, then strobes
// (RULE8) No write while flash self-program busy
// (RULE9) Strobe held until 8448 oscillator cycles
// (RULE10) Write timed on 1 MHz oscillator
// (RULE11) Write strobe stalls processor two cycles
// (RULE12) Read strobe fetches byte into data
// (RULE13) Read strobe stalls processor four cycles
// (RULE14) Busy write blocks reads and address changes
// (RULE15) Software keeps interrupts off during writes
// (RULE16) Power-down keeps write running, oscillator on
// (RULE17) Reset does not abort running write
// (RULE18) Address ten bits, upper bits read zero
// (RULE19) Data register feeds writes, takes reads
// (RULE20) Read strobe self-clears after read
package eac_pkg;
    // I/O register selects
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_ADDR_LO = 2'h1;
    localparam logic [1:0] SEL_ADDR_HI = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;
    // Control register bit positions
    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_MWE = 2;
    localparam int BIT_RIE = 3;
    localparam int ADDR_W = 10;
    localparam int ADDR_HI_W = ADDR_W - 8;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_PERIOD_NS = 1000;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int WRITE_OSC_CYCLES = 8448;
    localparam logic [2:0] MWE_CYCLES = 3'h4;
    localparam logic [2:0] WR_STALL = 3'h2;
    localparam logic [2:0] RD_STALL = 3'h4;
endpackage : eac_pkg

//--- common/eac_wr_if.sv
// Purpose: Carrier between control logic and write timer
// Assumes: Single core clock domain
// Notes: start is a one-cycle pulse, busy a level
`timescale 1ns/100ps
`default_nettype none
interface eac_wr_if;
    logic start;
    logic busy;
    logic osc_on;
    modport ctl (output start, input busy, input osc_on);
    modport tmr (input start, output busy, output osc_on);
endinterface : eac_wr_if
`default_nettype wire

//--- hdl/eac_wtimer.sv
// Purpose: Self-timed write duration counter on a 1 MHz enable
// Assumes: pwr_rst only on power loss; system reset never reaches here
// Notes: Oscillator enable stays up after a write until wake-up
`timescale 1ns/100ps
`default_nettype none
module eac_wtimer #(
    parameter int WRITE_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
    input wire logic clk,
    input wire logic pwr_rst,
    input wire logic sleep_pd,
    eac_wr_if.tmr wr
);
    localparam int DIV_W = $clog2(eac_pkg::OSC_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(eac_pkg::OSC_DIV - 1);
    localparam logic [13:0] CNT_LAST = 14'(WRITE_CYCLES - 1);
    logic [DIV_W-1:0] div_r;
    logic [13:0] cnt_r;
    logic busy_r;
    logic keep_r;
    wire tick = busy_r && (div_r == DIV_LAST);
    wire done = tick && (cnt_r == CNT_LAST);

    // Divider only runs during a write, so the 1 MHz phase starts at the strobe
    always_ff @(posedge clk or posedge pwr_rst)
    begin
        if (pwr_rst)
            div_r <= '0;
        else if (!busy_r || tick)
            div_r <= '0; // RULE10
        else
            div_r <= div_r + 1'b1;
    end

    // Oscillator cycle count; deliberately immune to system reset
    always_ff @(posedge clk or posedge pwr_rst)
    begin
        if (pwr_rst)
        begin
            busy_r <= 1'b0;
            cnt_r <= '0;
        end
        else if (wr.start && !busy_r)
        begin
            busy_r <= 1'b1; // RULE17
            cnt_r <= '0;
        end
        else if (done)
            busy_r <= 1'b0; // RULE9
        else if (tick)
            cnt_r <= cnt_r + 1'b1;
    end

    // Oscillator left running after a write until the device wakes
    always_ff @(posedge clk or posedge pwr_rst)
    begin
        if (pwr_rst)
            keep_r <= 1'b0;
        else if (wr.start)
            keep_r <= 1'b1; // RULE16
        else if (!busy_r && !sleep_pd)
            keep_r <= 1'b0;
    end

    assign wr.busy = busy_r;
    assign wr.osc_on = busy_r || keep_r;

    chk_tick_spacing: assert property (@(posedge clk) disable iff (pwr_rst)
        tick |-> $past(div_r) == DIV_W'(eac_pkg::OSC_DIV - 2)) else $error("Tick not one in twenty"); // RULE10
    chk_write_end: assert property (@(posedge clk) disable iff (pwr_rst)
        $fell(busy_r) |-> $past(cnt_r) == CNT_LAST) else $error("Write ended early or late"); // RULE9
    chk_sleep_run: assert property (@(posedge clk) disable iff (pwr_rst)
        ($fell(busy_r) && sleep_pd) |=> wr.osc_on) else $error("Oscillator off after write"); // RULE16
endmodule : eac_wtimer
`default_nettype wire

//--- hdl/eac_top.sv
// Purpose: EEPROM control, address and data registers with strobes and stalls
// Assumes: I/O port and memory array on CORE_CLK; array answers one cycle after MEM_RD
// Notes: POWER_RST clears the write timer only, SYS_RST the software registers
`timescale 1ns/100ps
`default_nettype none
module eac_top #(
    parameter int WRITE_OSC_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic POWER_RST,
    input wire logic [1:0] IO_SEL,
    input wire logic IO_WR,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    input wire logic GLOBAL_IE,
    input wire logic SELF_PROGRAM_BUSY,
    input wire logic SLEEP_PD,
    output logic CPU_STALL,
    output logic READY_IRQ,
    output logic OSC_RUN,
    output logic [9:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WR,
    output logic MEM_RD,
    input wire logic [7:0] MEM_RDATA
);
    logic rie_r;
    logic mwe_r;
    logic [2:0] mwe_cnt_r;
    logic [2:0] mwe_cnt_nxt;
    logic [9:0] addr_r;
    logic [7:0] data_r;
    logic rd_r;
    logic rd_cap_r;
    logic wr_go_r;
    logic [2:0] stall_r;
    eac_wr_if wr ();

    // Write decode
    wire ctrl_wr = IO_WR && (IO_SEL == eac_pkg::SEL_CTRL);
    wire busy = wr.busy;
    wire set_mwe = ctrl_wr && IO_WDATA[eac_pkg::BIT_MWE];
    wire wr_req = ctrl_wr && IO_WDATA[eac_pkg::BIT_WR];
    // A strobe without an armed master enable, or during flash programming, is dropped
    wire wr_take = wr_req && mwe_r && !busy && !SELF_PROGRAM_BUSY; // RULE5 RULE6 RULE8
    wire rd_take = ctrl_wr && IO_WDATA[eac_pkg::BIT_RD] && !busy; // RULE14
    wire addr_lo_wr = IO_WR && (IO_SEL == eac_pkg::SEL_ADDR_LO) && !busy; // RULE14
    wire addr_hi_wr = IO_WR && (IO_SEL == eac_pkg::SEL_ADDR_HI) && !busy; // RULE14
    wire data_wr = IO_WR && (IO_SEL == eac_pkg::SEL_DATA);

    // Control readback; upper nibble is hard zero
    wire [7:0] ctrl_rd = {4'h0, rie_r, mwe_r, busy, rd_r}; // RULE1
    wire [7:0] addr_hi_rd = {6'h00, addr_r[9:8]}; // RULE18

    assign IO_RDATA = (IO_SEL == eac_pkg::SEL_CTRL) ? ctrl_rd :
                      (IO_SEL == eac_pkg::SEL_ADDR_LO) ? addr_r[7:0] :
                      (IO_SEL == eac_pkg::SEL_ADDR_HI) ? addr_hi_rd : data_r;

    // Ready interrupt stays asserted while no write runs
    assign READY_IRQ = rie_r && GLOBAL_IE && !busy; // RULE2 RULE3
    assign CPU_STALL = (stall_r != 3'h0);
    assign OSC_RUN = wr.osc_on;
    assign MEM_ADDR = addr_r;
    assign MEM_WDATA = data_r;
    assign MEM_WR = wr_go_r;
    assign MEM_RD = rd_r;
    assign wr.start = wr_take;

    // Master enable window counter
    assign mwe_cnt_nxt = set_mwe ? eac_pkg::MWE_CYCLES - 3'h1 :
                         (mwe_cnt_r != 3'h0) ? mwe_cnt_r - 3'h1 : 3'h0;

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mwe_r <= 1'b0;
            mwe_cnt_r <= 3'h0;
        end
        else
        begin
            mwe_cnt_r <= mwe_cnt_nxt;
            mwe_r <= set_mwe || (mwe_cnt_r != 3'h0); // RULE4
        end
    end

    // Interrupt enable bit
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            rie_r <= 1'b0;
        else if (ctrl_wr)
            rie_r <= IO_WDATA[eac_pkg::BIT_RIE]; // RULE2
    end

    // Address register, frozen while a write runs
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            addr_r <= 10'h000;
        else if (addr_lo_wr)
            addr_r[7:0] <= IO_WDATA;
        else if (addr_hi_wr)
            addr_r[9:8] <= IO_WDATA[eac_pkg::ADDR_HI_W-1:0]; // RULE18
    end

    // Data register: software load, or array byte after a read
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            data_r <= eac_pkg::RST_BYTE;
        else if (rd_cap_r)
            data_r <= MEM_RDATA; // RULE12 RULE19
        else if (data_wr)
            data_r <= IO_WDATA; // RULE19
    end

    // Read strobe and capture, both self-clearing
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rd_r <= 1'b0;
            rd_cap_r <= 1'b0;
            wr_go_r <= 1'b0;
        end
        else
        begin
            rd_r <= rd_take; // RULE12
            rd_cap_r <= rd_r; // RULE20
            wr_go_r <= wr_take; // RULE5
        end
    end

    // Stall counter; the capture lands inside the read stall
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            stall_r <= 3'h0;
        else if (rd_take)
            stall_r <= eac_pkg::RD_STALL; // RULE13
        else if (wr_take)
            stall_r <= eac_pkg::WR_STALL; // RULE11
        else if (stall_r != 3'h0)
            stall_r <= stall_r - 3'h1;
    end

    eac_wtimer #(
        .WRITE_CYCLES(WRITE_OSC_CYCLES)
    ) u_wtimer (
        .clk(CORE_CLK),
        .pwr_rst(POWER_RST),
        .sleep_pd(SLEEP_PD),
        .wr(wr.tmr)
    );

    // The bit still reads one in the cycle after the fourth edge's sample, so look one edge later
    chk_mwe_timeout: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (set_mwe ##1 !set_mwe [*4]) |=> !mwe_r) else $error("Master enable not cleared"); // RULE4
    chk_mwe_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        set_mwe |=> mwe_r [*4]) else $error("Master enable dropped early"); // RULE4
    chk_no_arm_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (wr_req && !mwe_r) |-> !wr.start) else $error("Write started unarmed"); // RULE6
    chk_write_start: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || POWER_RST)
        (wr_req && mwe_r && !busy && !SELF_PROGRAM_BUSY) |=> busy && MEM_WR) else $error("Write not started"); // RULE5
    // A read strobe in the same write takes the longer stall
    chk_write_stall: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (wr_take && !rd_take) |=> CPU_STALL [*2] ##1 !CPU_STALL)
        else $error("Write stall not two cycles"); // RULE11
    chk_read_stall: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        rd_take |=> CPU_STALL [*4] ##1 !CPU_STALL) else $error("Read stall not four cycles"); // RULE13
    chk_read_data: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        rd_take |=> MEM_RD ##1 !rd_r ##1 data_r == $past(MEM_RDATA)) else $error("Read byte not captured"); // RULE12
    chk_busy_block: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        busy |-> !MEM_RD ##0 ($stable(addr_r) || !busy)) else $error("Access during write"); // RULE14
    chk_ctrl_upper: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (IO_SEL == eac_pkg::SEL_CTRL) |-> IO_RDATA[7:4] == 4'h0) else $error("Reserved bits not zero"); // RULE1
    chk_ready_irq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (rie_r && GLOBAL_IE) |-> (READY_IRQ == !ctrl_rd[eac_pkg::BIT_WR])) else $error("Ready irq mismatch"); // RULE3
    chk_addr_hi: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (IO_SEL == eac_pkg::SEL_ADDR_HI) |-> IO_RDATA[7:2] == 6'h00) else $error("Address upper bits set"); // RULE18
    // A normal finish leaves the oscillator on for a cycle; a reset-killed write would drop both
    chk_reset_write: assert property (@(posedge CORE_CLK) disable iff (POWER_RST)
        (SYS_RST && busy) |=> busy || OSC_RUN) else $error("Reset aborted write"); // RULE17
endmodule : eac_top
`default_nettype wire

//--- verification/test_eeprom_access_control.sv
// Purpose: Self-checking bench for the EEPROM access control block
// Assumes: Write time cut to 3 oscillator ticks, so one write lasts about 60 core cycles
// Notes: Inputs move on the falling edge; the array model returns the inverted low address byte
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_access_control;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic prst = 1'b1;
    logic [1:0] sel = 2'h0;
    logic iwr = 1'b0;
    logic [7:0] wd = 8'h00;
    logic gie = 1'b1;
    logic spb = 1'b0;
    logic slp = 1'b0;
    logic [7:0] mrdata = 8'h00;
    wire logic [7:0] rd;
    wire logic [7:0] mwd;
    wire logic [9:0] maddr;
    wire logic stall, irq, osc, mwr, mrd;
    int num_errors = 0;
    int cmp_count = 0;

    eac_top #(.WRITE_OSC_CYCLES(3)) uut (.CORE_CLK(clk), .SYS_RST(rst), .POWER_RST(prst), .IO_SEL(sel),
        .IO_WR(iwr), .IO_WDATA(wd), .IO_RDATA(rd), .GLOBAL_IE(gie), .SELF_PROGRAM_BUSY(spb),
        .SLEEP_PD(slp), .CPU_STALL(stall), .READY_IRQ(irq), .OSC_RUN(osc), .MEM_ADDR(maddr),
        .MEM_WDATA(mwd), .MEM_WR(mwr), .MEM_RD(mrd), .MEM_RDATA(mrdata));

    // Core clock, 50 ns period
    always #25 clk = ~clk;

    // Array model; the address settles long before a read, so a falling-edge update is early enough
    always @(negedge clk) mrdata <= ~maddr[7:0];

    task automatic results;
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // One register write, taken at the rising edge between two falling edges
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge clk);
        sel = s;
        wd = d;
        iwr = 1'b1;
        @(negedge clk);
        iwr = 1'b0;
    endtask : wr

    task automatic rdc(input logic [1:0] s, input logic [9:0] e);
        sel = s;
        #1 chk({2'h0, rd}, e);
    endtask : rdc

    // Arm, then strobe after gap plus one idle cycles; go says whether a write must start
    // Interrupts stay off across the arm-to-strobe window; master enable still reads one for gaps below two
    task automatic try_write(input int gap, input logic sp, input logic go);
        spb = sp;
        gie = 1'b0;
        wr(eac_pkg::SEL_CTRL, 8'h0c);
        rdc(eac_pkg::SEL_CTRL, 10'h00c);
        repeat (gap) @(negedge clk);
        wr(eac_pkg::SEL_CTRL, 8'h0a);
        gie = 1'b1;
        chk({8'h0, mwr, stall}, {8'h0, go, go});
        rdc(eac_pkg::SEL_CTRL, {6'h00, 1'b1, gap < 2, go, 1'b0});
        spb = 1'b0;
        if (go)
        begin
            chk({9'h0, irq}, 10'h000);
            @(negedge clk);
            chk({8'h0, mwr, stall}, 10'h001);
            @(negedge clk);
            chk({8'h0, mwr, stall}, 10'h000);
        end
    endtask : try_write

    // Poll the write strobe bit under a bound; lo is the least wait expected
    task automatic wait_done(input int lo);
        int n;
        n = 0;
        sel = eac_pkg::SEL_CTRL;
        while (rd[1] !== 1'b0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk({9'h0, n >= lo && n <= 64}, 10'h001);
    endtask : wait_done

    task automatic t_regs;
        rdc(eac_pkg::SEL_CTRL, 10'h000);
        rdc(eac_pkg::SEL_ADDR_HI, 10'h000);
        wr(eac_pkg::SEL_ADDR_HI, 8'hff);
        rdc(eac_pkg::SEL_ADDR_HI, 10'h003);
        wr(eac_pkg::SEL_CTRL, 8'hf0);
        rdc(eac_pkg::SEL_CTRL, 10'h000);
    endtask : t_regs

    // Full write while power-down is requested, then the ready interrupt gating
    task automatic t_write;
        wr(eac_pkg::SEL_ADDR_LO, 8'h5a);
        wr(eac_pkg::SEL_ADDR_HI, 8'h03);
        wr(eac_pkg::SEL_DATA, 8'hc3);
        slp = 1'b1;
        try_write(2, 1'b0, 1'b1);
        chk(maddr, 10'h35a);
        chk({2'h0, mwd}, 10'h0c3);
        wait_done(45);
        chk({8'h0, osc, irq}, 10'h003);
        gie = 1'b0;
        @(negedge clk);
        chk({9'h0, irq}, 10'h000);
        gie = 1'b1;
        slp = 1'b0;
        wr(eac_pkg::SEL_CTRL, 8'h00);
        chk({8'h0, osc, irq}, 10'h000);
    endtask : t_write

    // Late strobe, busy flash and a combined arm-and-strobe must all be refused
    task automatic t_refuse;
        try_write(3, 1'b0, 1'b0);
        try_write(0, 1'b1, 1'b0);
        // Let the earlier arm time out, else the strobe below would still be inside its window
        repeat (4) @(negedge clk);
        wr(eac_pkg::SEL_CTRL, 8'h06);
        chk({9'h0, mwr}, 10'h000);
    endtask : t_refuse

    task automatic t_read;
        wr(eac_pkg::SEL_ADDR_LO, 8'h55);
        wr(eac_pkg::SEL_ADDR_HI, 8'h01);
        wr(eac_pkg::SEL_CTRL, 8'h01);
        chk({7'h0, mrd, stall, rd[0]}, 10'h007);
        @(negedge clk);
        chk({9'h0, mrd}, 10'h000);
        @(negedge clk);
        rdc(eac_pkg::SEL_DATA, {2'h0, ~8'h55});
        chk({9'h0, stall}, 10'h001);
        @(negedge clk);
        chk({9'h0, stall}, 10'h001);
        @(negedge clk);
        chk({9'h0, stall}, 10'h000);
        rdc(eac_pkg::SEL_CTRL, 10'h000);
    endtask : t_read

    // Address and read strobe refused while busy; a reset must not end the write
    task automatic t_busy;
        try_write(1, 1'b0, 1'b1);
        wr(eac_pkg::SEL_ADDR_LO, 8'h00);
        rdc(eac_pkg::SEL_ADDR_LO, 10'h055);
        wr(eac_pkg::SEL_CTRL, 8'h09);
        chk({9'h0, mrd}, 10'h000);
        rdc(eac_pkg::SEL_CTRL, 10'h00a);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rdc(eac_pkg::SEL_CTRL, 10'h002);
        wait_done(0);
    endtask : t_busy

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        prst = 1'b0;
        t_regs;
        t_write;
        t_refuse;
        t_read;
        t_busy;
        results;
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clk);
        num_errors++;
        results;
    end
endmodule : test_eeprom_access_control
`default_nettype wire
